// >>> verilog/host_port_pkg.sv
package host_port_pkg;
	localparam int unsigned ADDR_W = 11;
	localparam int unsigned REG_ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned EXP_N = 5;
	localparam int unsigned CHAN_N = 14;
	localparam int unsigned CLK_HZ = 50_000_000;
	// Least reset hold time, in nanoseconds
	localparam int unsigned RESET_HOLD_NS = 10_000;
	localparam int unsigned RESET_HOLD_CYC =
		(RESET_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// Device select codes on the upper address bits
	localparam logic [2:0] SEL_SELF = 3'h0;
	localparam logic [2:0] SEL_RSVD = 3'h6;
	localparam logic [2:0] SEL_ALL = 3'h7;
	// Bus type codes
	localparam logic [2:0] TYPE_SEP_STROBE = 3'h0;
	localparam logic [2:0] TYPE_RW_STROBE = 3'h1;
	localparam logic [2:0] TYPE_SYNC = 3'h7;
	localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
	localparam logic [EXP_N-1:0] EXP_SEL_IDLE = 5'h1f;

	typedef enum logic [1:0] {
		MODE_SEP,
		MODE_RW,
		MODE_SYNC,
		MODE_NONE
	} bus_mode_t;

	// One register access toward the internal register space
	typedef struct packed {
		logic wr;
		logic rd;
		logic [REG_ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	// Line-side controls driven from the pins and channel registers
	typedef struct packed {
		logic [CHAN_N-1:0] rx_on;
		logic [CHAN_N-1:0] rx_term_int;
	} line_ctl_t;
endpackage

// >>> verilog/chip_select_decode.sv
module chip_select_decode (
	// Upper address and select
	input wire logic [2:0] i_code,
	input wire logic i_sel,
	// Decoded selects
	output logic o_self,
	output logic [host_port_pkg::EXP_N-1:0] o_exp
);
	always_comb begin
		o_self = 1'b0;
		o_exp = '0;
		if (i_sel) begin
			case (i_code)
				host_port_pkg::SEL_SELF: o_self = 1'b1;
				host_port_pkg::SEL_ALL: begin
					o_self = 1'b1;
					o_exp = '1;
				end
				host_port_pkg::SEL_RSVD: o_self = 1'b0;
				default: o_exp[i_code - 3'h1] = 1'b1;
			endcase
		end
	end
endmodule

// >>> verilog/host_port_chip_select_decoder.sv
// Summary of operation
// - Select input low enables the port; high makes it ignore the bus.
// - Address bits 10:8 pick self, expansion 1-5, reserved, or all.
// - Low eight address bits index registers directly, no paging.
// - Eight-bit data bus; device drives it only during its reads.
// - Type pins pick separate strobes, read/write strobe, or synchronous.
// - Synchronous mode times accesses from the host bus clock.
// - Reset held low over ten microseconds restores register defaults.
// - Interrupt pulls low on alarm change; releases after status read.
// - No interrupt unless the global interrupt enable bit is set.
// - Receivers off at power-up; pin low forces all off, high follows regs.
// - Termination off at power-up; enabled per channel unless pin controls.
// - With pin control set, termination pin 1 internal, 0 external.
// - Five companion selects come from the top three address bits.
module host_port_chip_select_decoder #(
	parameter int unsigned RESET_HOLD = host_port_pkg::RESET_HOLD_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// Host bus
	input wire logic i_host_sel_n,
	input wire logic i_address_latch_strobe,
	input wire logic i_wr_rw,
	input wire logic i_rd_we,
	input wire logic i_host_clk,
	input wire logic [2:0] i_host_type_select,
	input wire logic [host_port_pkg::ADDR_W-1:0] i_addr,
	input wire logic [host_port_pkg::DATA_W-1:0] i_data,
	output logic [host_port_pkg::DATA_W-1:0] o_data,
	output logic o_data_oe_n,
	output logic o_access_ready_n,
	// Hardware reset pin and interrupt
	input wire logic i_hw_reset_n,
	input wire logic i_alarm_change,
	output logic o_irq_n,
	output logic o_irq_oe_n,
	// Global register bits and line controls
	input wire logic i_global_irq_enable,
	input wire logic i_rx_termination_pin_control,
	input wire logic i_receiver_power_pin,
	input wire logic i_rx_termination_pin,
	input wire logic [host_port_pkg::CHAN_N-1:0] i_chan_rx_on,
	input wire logic [host_port_pkg::CHAN_N-1:0] i_chan_rx_term,
	output host_port_pkg::line_ctl_t o_line_ctl,
	// Expansion selects
	output logic [host_port_pkg::EXP_N-1:0] o_expansion_select_out_n,
	// Internal register space
	output host_port_pkg::reg_req_t o_reg_req,
	input wire logic [host_port_pkg::DATA_W-1:0] i_reg_rdata,
	input wire logic i_status_read,
	output logic o_regs_default
);
	typedef enum {ST_IDLE, ST_ACCESS, ST_DONE} state_t;

	function automatic host_port_pkg::bus_mode_t decode_mode(
		input logic [2:0] sel
	);
		case (sel)
			host_port_pkg::TYPE_SEP_STROBE: decode_mode = host_port_pkg::MODE_SEP;
			host_port_pkg::TYPE_RW_STROBE: decode_mode = host_port_pkg::MODE_RW;
			host_port_pkg::TYPE_SYNC: decode_mode = host_port_pkg::MODE_SYNC;
			default: decode_mode = host_port_pkg::MODE_NONE;
		endcase
	endfunction

	host_port_pkg::bus_mode_t mode;
	state_t state_r, state_nxt;
	logic [host_port_pkg::ADDR_W-1:0] addr_r, addr_nxt;
	logic [host_port_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
	logic rd_r, rd_nxt;
	logic wr_r, wr_nxt;
	logic host_clk_r, host_clk_nxt;
	logic ale_r, ale_nxt;
	logic [31:0] rst_cnt_r, rst_cnt_nxt;
	logic regs_default_r, regs_default_nxt;
	logic irq_r, irq_nxt;
	logic host_clk_rise, strobe_rd, strobe_wr, strobe_any, self_sel;
	logic [host_port_pkg::EXP_N-1:0] exp_sel;
	host_port_pkg::reg_req_t req;

	assign mode = decode_mode(i_host_type_select);

	// Sync mode only acts on a rising host clock edge
	assign host_clk_rise = i_host_clk & ~host_clk_r;

	always_comb begin
		strobe_rd = 1'b0;
		strobe_wr = 1'b0;
		case (mode)
			host_port_pkg::MODE_SEP: begin
				strobe_rd = ~i_rd_we;
				strobe_wr = ~i_wr_rw;
			end
			host_port_pkg::MODE_RW: begin
				strobe_rd = ~i_rd_we & i_wr_rw;
				strobe_wr = ~i_rd_we & ~i_wr_rw;
			end
			host_port_pkg::MODE_SYNC: begin
				strobe_rd = host_clk_rise & ale_r & i_wr_rw;
				strobe_wr = host_clk_rise & ale_r & ~i_wr_rw;
			end
			default: begin
				strobe_rd = 1'b0;
				strobe_wr = 1'b0;
			end
		endcase
	end
	assign strobe_any = strobe_rd | strobe_wr;

	chip_select_decode u_decode (
		.i_code(addr_r[host_port_pkg::ADDR_W-1:host_port_pkg::REG_ADDR_W]),
		.i_sel(~i_host_sel_n && state_r != ST_IDLE),
		.o_self(self_sel),
		.o_exp(exp_sel)
	);

	always_comb begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		rdata_nxt = rdata_r;
		rd_nxt = rd_r;
		wr_nxt = wr_r;
		req = '0;
		if (i_host_sel_n) begin
			state_nxt = ST_IDLE;
			rd_nxt = 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (i_address_latch_strobe) begin
						addr_nxt = i_addr;
					end
					if (strobe_any) begin
						state_nxt = ST_ACCESS;
						// The sync strobe lasts one cycle, so keep its direction
						wr_nxt = strobe_wr;
					end
				end
				ST_ACCESS: begin
					req.addr = addr_r[host_port_pkg::REG_ADDR_W-1:0];
					req.wdata = i_data;
					req.rd = self_sel & ~wr_r;
					req.wr = self_sel & wr_r;
					rd_nxt = self_sel & ~wr_r;
					rdata_nxt = i_reg_rdata;
					state_nxt = ST_DONE;
				end
				ST_DONE: begin
					// Hold the answer until the strobe drops, except in sync mode, which returns at once
					if (!strobe_any && mode != host_port_pkg::MODE_SYNC) begin
						state_nxt = ST_IDLE;
						rd_nxt = 1'b0;
					end else if (mode == host_port_pkg::MODE_SYNC) begin
						state_nxt = ST_IDLE;
						rd_nxt = 1'b0;
					end
				end
				default: state_nxt = ST_IDLE;
			endcase
		end
	end

	// Reset pin is filtered so glitches shorter than the hold time do nothing
	always_comb begin
		rst_cnt_nxt = rst_cnt_r;
		regs_default_nxt = 1'b0;
		if (i_hw_reset_n) begin
			rst_cnt_nxt = '0;
		end else if (rst_cnt_r < RESET_HOLD) begin
			rst_cnt_nxt = rst_cnt_r + 32'h1;
		end else begin
			regs_default_nxt = 1'b1;
		end
	end

	always_comb begin
		irq_nxt = irq_r;
		if (regs_default_r || !i_global_irq_enable) begin
			irq_nxt = 1'b0;
		end else if (i_alarm_change) begin
			irq_nxt = 1'b1;
		end else if (i_status_read) begin
			irq_nxt = 1'b0;
		end
	end

	assign host_clk_nxt = i_host_clk;
	assign ale_nxt = i_address_latch_strobe;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r <= ST_IDLE;
			addr_r <= '0;
			rdata_r <= host_port_pkg::RDATA_RST;
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			host_clk_r <= 1'b0;
			ale_r <= 1'b0;
			rst_cnt_r <= '0;
			regs_default_r <= 1'b1;
			irq_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
			rdata_r <= rdata_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			host_clk_r <= host_clk_nxt;
			ale_r <= ale_nxt;
			rst_cnt_r <= rst_cnt_nxt;
			regs_default_r <= regs_default_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign o_reg_req = req;
	assign o_regs_default = regs_default_r;
	assign o_data = rdata_r;
	assign o_data_oe_n = ~(rd_r & ~i_host_sel_n);
	// Deselect drops ready at once, not a cycle later
	assign o_access_ready_n = ~(state_r == ST_DONE && !i_host_sel_n);
	assign o_irq_n = 1'b0;
	assign o_irq_oe_n = ~irq_r;
	assign o_expansion_select_out_n = ~exp_sel;

	// Pin low wins; reset state leaves receivers off and inputs open
	always_comb begin
		o_line_ctl.rx_on = '0;
		o_line_ctl.rx_term_int = '0;
		if (!regs_default_r) begin
			if (i_receiver_power_pin) begin
				o_line_ctl.rx_on = i_chan_rx_on;
			end
			if (i_rx_termination_pin_control) begin
				o_line_ctl.rx_term_int =
					{host_port_pkg::CHAN_N{i_rx_termination_pin}};
			end else begin
				o_line_ctl.rx_term_int = i_chan_rx_term;
			end
		end
	end
endmodule

// >>> dv/host_port_props.sv
module host_port_props (
	// Watched ports
	input wire logic i_clk, i_arst_n, i_host_sel_n, i_hw_reset_n,
	input wire logic i_alarm_change, i_status_read, i_global_irq_enable,
	input wire logic i_rx_termination_pin_control, i_receiver_power_pin,
	input wire logic i_rx_termination_pin, o_data_oe_n, o_access_ready_n,
	input wire logic o_irq_oe_n, o_regs_default,
	input wire logic [13:0] i_chan_rx_on, i_chan_rx_term,
	input wire logic [4:0] o_expansion_select_out_n,
	input wire host_port_pkg::line_ctl_t o_line_ctl,
	input wire host_port_pkg::reg_req_t o_reg_req
);
	timeunit 1ns;
	timeprecision 1ns;
	logic req;
	assign req = o_reg_req.wr || o_reg_req.rd;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	chk_sel_idle: assert property (
		i_host_sel_n |=> o_access_ready_n && o_data_oe_n) else $error("sel");
	chk_req_ready: assert property (
		req && !i_host_sel_n |=> !o_access_ready_n) else $error("ready");
	chk_req_pulse: assert property (req |=> !req)
		else $error("pulse");
	// Only none, one or all five may be low: 110 must pick nothing
	chk_exp_code: assert property (
		$countones(~o_expansion_select_out_n) inside {0, 1, 5})
		else $error("exp");
	chk_irq_raise: assert property (
		i_global_irq_enable && i_alarm_change && !o_regs_default |=>
		!o_irq_oe_n)
		else $error("irq");
	chk_irq_gate: assert property (
		!i_global_irq_enable && o_irq_oe_n |=> o_irq_oe_n) else $error("gie");
	chk_rx_power: assert property (
		o_line_ctl.rx_on == (i_receiver_power_pin && !o_regs_default ?
		i_chan_rx_on : 14'h0)) else $error("rx on");
	chk_rx_term: assert property (o_line_ctl.rx_term_int ==
		(o_regs_default ? 14'h0 : i_rx_termination_pin_control ?
		{14{i_rx_termination_pin}} : i_chan_rx_term)) else $error("term");
	chk_dflt_clear: assert property (
		i_hw_reset_n |=> !o_regs_default) else $error("default");
	cover property (!o_access_ready_n && !o_data_oe_n);
	cover property (!o_irq_oe_n);
	cover property (o_regs_default);
endmodule

bind host_port_chip_select_decoder host_port_props i_host_port_props (.*);

// >>> dv/host_cpu_model.sv
module host_cpu_model (
	// Clock and answer
	input wire logic clk,
	input wire logic rdy_n,
	input wire logic [7:0] dq,
	// Host side
	output logic sel_n, ale, wr_rw, rd_we, hclk, drv,
	output logic [10:0] addr,
	output logic [7:0] wd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{sel_n, ale, wr_rw, rd_we, hclk, drv} = 6'h2c;
		addr = 11'h0;
		wd = 8'h0;
	end
	task automatic access(input logic [2:0] m, input logic [10:0] a,
			input logic w, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		{sel_n, ale, drv, addr, wd} = {2'h1, w, a, d};
		@(posedge clk);
		#1;
		ale = m == 3'h7;
		hclk = m == 3'h7;
		if (m == 3'h7 || m == 3'h1) wr_rw = !w;
		else if (w) wr_rw = 1'h0;
		rd_we = !(m == 3'h1 || (m != 3'h7 && !w));
		do @(posedge clk); while (rdy_n && ++n < 20);
		q = dq;
		#1;
		{sel_n, ale, wr_rw, rd_we, hclk, drv} = 6'h2c;
		// Released lines must not keep showing the old address
		addr = ~a;
		do @(posedge clk); while (!rdy_n && ++n < 40);
		#1;
	endtask
endmodule

// >>> dv/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'h0, i_arst_n = 1'h0, i_hw_reset_n = 1'h1;
	logic i_alarm_change = 1'h0, i_status_read = 1'h0;
	logic i_global_irq_enable = 1'h0, i_rx_termination_pin_control = 1'h0;
	logic i_receiver_power_pin = 1'h0, i_rx_termination_pin = 1'h0;
	logic [2:0] i_host_type_select = 3'h0;
	logic [13:0] i_chan_rx_on = 14'h0, i_chan_rx_term = 14'h0;
	logic [7:0] i_reg_rdata = 8'h0, i_data, o_data, wd, q, d;
	logic [10:0] i_addr, a;
	logic i_host_sel_n, i_address_latch_strobe, i_wr_rw, i_rd_we, i_host_clk;
	logic o_data_oe_n, o_access_ready_n, o_irq_n, o_irq_oe_n;
	logic o_regs_default, drv, w, self;
	logic [4:0] o_expansion_select_out_n, exp_sel = 5'h1f;
	logic [2:0] modes [4] = '{3'h0, 3'h1, 3'h7, 3'h2};
	host_port_pkg::line_ctl_t o_line_ctl;
	host_port_pkg::reg_req_t o_reg_req, rq[$];
	int err_total = 0, compares = 0, cyc = 0, seed = 32'h877a8d24;
	always #10 i_clk = ~i_clk;
	// The data pins are pulled low when nobody drives them
	assign i_data = !o_data_oe_n ? o_data : drv ? wd : 8'h00;
	host_cpu_model i_host_cpu_model (.clk(i_clk), .rdy_n(o_access_ready_n),
		.dq(i_data), .sel_n(i_host_sel_n), .ale(i_address_latch_strobe),
		.wr_rw(i_wr_rw), .rd_we(i_rd_we), .hclk(i_host_clk), .drv(drv),
		.addr(i_addr), .wd(wd));
	host_port_chip_select_decoder #(.RESET_HOLD(4))
		i_host_port_chip_select_decoder (.*);
	task automatic check(string s, logic [31:0] seen, logic [31:0] want);
		compares++;
		if (seen !== want) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", s, want, seen);
		end
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic tick;
		@(posedge i_clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		tick();
		s = 1'h1;
		tick();
		s = 1'h0;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc > 4000) begin
			err_total++;
			complete_run();
		end
		if (!o_access_ready_n) check("exp_sel", o_expansion_select_out_n,
			exp_sel);
		if (o_reg_req.wr || o_reg_req.rd) begin
			if (rq.size() == 0) check("extra req", 1, 0);
			else check("req", {o_reg_req.wr, o_reg_req.rd, o_reg_req.addr,
				o_reg_req.wr ? o_reg_req.wdata : 8'h0}, rq.pop_front());
		end
	end
	initial begin
		repeat (20) @(posedge i_clk);
		#1;
		i_arst_n = 1'h1;
		tick();
		check("regs_default", o_regs_default, 0);
		foreach (modes[m]) for (int c = 0; c < 8; c++) begin
			w = 1'($random(seed));
			d = 8'($random(seed));
			a = {c[2:0], 8'($random(seed))};
			i_reg_rdata = 8'($random(seed));
			i_host_type_select = modes[m];
			self = modes[m] != 3'h2 && (c == 0 || c == 7);
			exp_sel = 5'h1f;
			if (modes[m] != 3'h2 && c == 7) exp_sel = 5'h00;
			else if (modes[m] != 3'h2 && c > 0 && c < 6)
				exp_sel = ~(5'h01 << (c - 1));
			if (self) rq.push_back({w, !w, a[7:0], w ? d : 8'h0});
			i_host_cpu_model.access(modes[m], a, w, d, q);
			if (self && !w) check("rdata", q, i_reg_rdata);
		end
		check("queue", rq.size(), 0);
		$display("bus accesses done");
		pulse(i_alarm_change);
		check("irq off", o_irq_oe_n, 1);
		i_global_irq_enable = 1'h1;
		pulse(i_alarm_change);
		check("irq on", o_irq_oe_n, 0);
		check("irq pin", o_irq_n, 0);
		pulse(i_status_read);
		check("irq clear", o_irq_oe_n, 1);
		$display("interrupt done");
		i_chan_rx_on = 14'($random(seed));
		i_chan_rx_term = 14'($random(seed));
		for (int k = 0; k < 8; k++) begin
			{i_receiver_power_pin, i_rx_termination_pin_control,
				i_rx_termination_pin} = k[2:0];
			#1;
			check("line_ctl", o_line_ctl, {k[2] ? i_chan_rx_on : 14'h0,
				k[1] ? {14{k[0]}} : i_chan_rx_term});
		end
		$display("line controls done");
		i_hw_reset_n = 1'h0;
		repeat (4) tick();
		check("default early", o_regs_default, 0);
		repeat (2) tick();
		check("default held", o_regs_default, 1);
		i_hw_reset_n = 1'h1;
		repeat (2) tick();
		check("default clear", o_regs_default, 0);
		$display("hardware reset done");
		complete_run();
	end
endmodule
